// ==== hdl/eeprom_prot_pkg.sv ====
`default_nettype none
package eeprom_prot_pkg;
   localparam logic [7:0] OP_LATCH_SET = 8'h06;
   localparam logic [7:0] OP_LATCH_CLR = 8'h04;
   localparam logic [7:0] OP_STAT_RD = 8'h05;
   localparam logic [7:0] OP_STAT_WR = 8'h01;
   localparam logic [7:0] OP_ARRAY_WR = 8'h02;
   localparam int ADDR_W = 10;
   localparam logic [ADDR_W-1:0] PROT_QTR_BASE = 10'h300;
   localparam logic [ADDR_W-1:0] PROT_HALF_BASE = 10'h200;
   localparam logic [1:0] BP_NONE = 2'h0;
   localparam logic [1:0] BP_QTR = 2'h1;
   localparam logic [1:0] BP_HALF = 2'h2;
   localparam logic [1:0] BP_ALL = 2'h3;
   localparam logic NV_PIN_EN_RST = 1'b0;
   localparam logic [1:0] NV_BP_RST = 2'h0;
   localparam logic LATCH_RST = 1'b0;
   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam int unsigned WR_CYCLE_NS = 100000;
   localparam int unsigned WR_CYCLE_CLKS = WR_CYCLE_NS / CLK_PERIOD_NS;
   localparam logic [2:0] BYTE_ADDR_LO = 3'h2;
   localparam logic [2:0] BYTE_STAT_DATA = 3'h1;
   localparam logic [2:0] BYTE_WR_MIN = 3'h4;
   localparam logic [3:0] PIN_SYNC_RST = 4'h6;

   typedef struct packed {
      logic sck;
      logic csN;
      logic si;
      logic wpN;
   } spi_pins_t;

   typedef struct packed {
      logic protect_pin_enable;
      logic [2:0] dontCare;
      logic block_protect_high;
      logic block_protect_low;
      logic latch_state_bit;
      logic busy_flag;
   } protection_status_t;

   typedef enum logic [5:0] {
      PH_IDLE = 6'b000001,
      PH_CMD = 6'b000010,
      PH_ADDR = 6'b000100,
      PH_DATA = 6'b001000,
      PH_STAT = 6'b010000,
      PH_SKIP = 6'b100000
   } phase_t;
endpackage
`default_nettype wire

// ==== hdl/pin_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 4,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic clk, // sampling clock
   input wire logic rst_n, // async reset, active low
   input wire logic [WIDTH-1:0] d, // asynchronous inputs
   output logic [WIDTH-1:0] q // synchronised copy
);
   logic [WIDTH-1:0] meta_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= RESET_VAL;
         q <= RESET_VAL;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule
`default_nettype wire

// ==== hdl/spi_eeprom_write_protect_status.sv ====
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// [RULE1] no internal write without latch set
// [RULE2] latch-set sets, latch-clear clears latch
// [RULE3] latch cleared at reset, clear, writes
// [RULE4] status read answered even while busy
// [RULE5] status layout: pin-enable,x,x,x,bph,bpl,latch,busy
// [RULE6] busy reads one during write, read-only
// [RULE7] latch bit read-only, follows set/clear
// [RULE8] latch zero blocks every array write
// [RULE9] block-protect bits only via status write
// [RULE10] block-protect codes select protected address range
// [RULE11] nonvolatile pin-enable gates protect pin
// [RULE12] hw protection: pin low and enable
// [RULE13] hw protection blocks only status writes
// [RULE14] master ends write frames on byte boundary
// [RULE15] accesses during write cycle ignored
// [RULE16] power-on: deselected, latch clear, output off
// [RULE17] opcodes 06,04,05,01 sent msb first
// [RULE18] latch set needs select raised after opcode
// [RULE19] started write completes despite pin change
// [RULE20] status write ignores 6-4, busy then clear
module spi_eeprom_write_protect_status #(
   parameter int unsigned WR_CYCLE_CLKS = eeprom_prot_pkg::WR_CYCLE_CLKS
) (
   input wire logic mclk, // system clock, 50 MHz
   input wire logic rst_n, // async reset, active low
   input wire logic sck, // serial clock pin
   input wire logic csN, // chip select pin, active low
   input wire logic si, // serial data in pin
   input wire logic wpN, // write-protect pin, active low
   output logic so, // serial data out
   output logic soOeN, // low while so is driven
   output logic arrayWrGo, // pulse: array write cycle starts
   output logic [9:0] arrayWrAddr, // start address of that cycle
   output logic writeBusy, // self-timed cycle running
   output logic hwProtected // hardware protection in force
);
   eeprom_prot_pkg::spi_pins_t pinsIn, pinsSync;
   eeprom_prot_pkg::protection_status_t statusByte;
   eeprom_prot_pkg::phase_t phase_r;
   logic sckDly_r, csDly_r, sckRise, sckFall, csRise, selected, byteEnd;
   logic [2:0] bitCnt_r, byteCnt_r;
   logic [7:0] shift_r, byteIn, opcode_r, statusIn_r;
   logic [9:0] addr_r, arrayWrAddr_r;
   logic [1:0] blockProt_r;
   logic latch_r, pinEnable_r, pendStatus_r;
   logic frameOk, latchSetEv, latchClrEv, statusWrEv, arrayWrEv;
   logic hwProt, addrProt, statusGo, arrayGo, cycleStart, timerDone;
   logic so_r, soOeN_r, arrayWrGo_r, hwProtected_r;

   assign pinsIn = {sck, csN, si, wpN};

   pin_sync #(
      .WIDTH(4),
      .RESET_VAL(eeprom_prot_pkg::PIN_SYNC_RST)
   ) u_pin_sync (
      .clk(mclk),
      .rst_n(rst_n),
      .d(pinsIn),
      .q(pinsSync)
   );

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sckDly_r <= 1'b0;
         csDly_r <= 1'b1;
      end else begin
         sckDly_r <= pinsSync.sck;
         csDly_r <= pinsSync.csN;
      end
   end

   assign selected = ~pinsSync.csN;
   assign sckRise = pinsSync.sck & ~sckDly_r;
   assign sckFall = ~pinsSync.sck & sckDly_r;
   assign csRise = pinsSync.csN & ~csDly_r;
   assign byteIn = {shift_r[6:0], pinsSync.si};
   assign byteEnd = selected & sckRise & (bitCnt_r == 3'h7);

   // bit and byte counters restart with every frame
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         bitCnt_r <= 3'h0;
         byteCnt_r <= 3'h0;
         shift_r <= 8'h00;
      end else if (!selected) begin
         bitCnt_r <= 3'h0;
         byteCnt_r <= 3'h0;
      end else if (sckRise) begin
         bitCnt_r <= bitCnt_r + 3'h1;
         shift_r <= byteIn;
         // saturates: only "four or more" matters for array writes
         if (bitCnt_r == 3'h7 && byteCnt_r != 3'h7) begin
            byteCnt_r <= byteCnt_r + 3'h1;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         phase_r <= eeprom_prot_pkg::PH_IDLE;
         opcode_r <= 8'h00;
      end else if (!selected) begin
         phase_r <= eeprom_prot_pkg::PH_IDLE;
      end else begin
         unique case (phase_r)
            eeprom_prot_pkg::PH_IDLE: begin
               phase_r <= eeprom_prot_pkg::PH_CMD;
            end
            eeprom_prot_pkg::PH_CMD: begin
               if (byteEnd) begin
                  opcode_r <= byteIn;
                  if (byteIn == eeprom_prot_pkg::OP_STAT_RD) begin // RULE17
                     phase_r <= eeprom_prot_pkg::PH_STAT; // RULE4
                  end else if (writeBusy) begin
                     phase_r <= eeprom_prot_pkg::PH_SKIP; // RULE15
                  end else if (byteIn == eeprom_prot_pkg::OP_ARRAY_WR) begin
                     phase_r <= eeprom_prot_pkg::PH_ADDR;
                  end else if (byteIn == eeprom_prot_pkg::OP_STAT_WR ||
                               byteIn == eeprom_prot_pkg::OP_LATCH_SET ||
                               byteIn == eeprom_prot_pkg::OP_LATCH_CLR) begin // RULE17
                     phase_r <= eeprom_prot_pkg::PH_DATA;
                  end else begin
                     phase_r <= eeprom_prot_pkg::PH_SKIP;
                  end
               end
            end
            eeprom_prot_pkg::PH_ADDR: begin
               if (byteEnd && byteCnt_r == eeprom_prot_pkg::BYTE_ADDR_LO) begin
                  phase_r <= eeprom_prot_pkg::PH_DATA;
               end
            end
            eeprom_prot_pkg::PH_DATA: begin
               phase_r <= eeprom_prot_pkg::PH_DATA;
            end
            eeprom_prot_pkg::PH_STAT: begin
               phase_r <= eeprom_prot_pkg::PH_STAT;
            end
            eeprom_prot_pkg::PH_SKIP: begin
               phase_r <= eeprom_prot_pkg::PH_SKIP;
            end
            default: begin
               phase_r <= eeprom_prot_pkg::PH_IDLE;
            end
         endcase
      end
   end

   // only the low address bits exist; the upper six are don't care
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         addr_r <= 10'h000;
         statusIn_r <= 8'h00;
      end else if (byteEnd) begin
         if (phase_r == eeprom_prot_pkg::PH_ADDR) begin
            if (byteCnt_r == eeprom_prot_pkg::BYTE_ADDR_LO) begin
               addr_r[7:0] <= byteIn;
            end else begin
               addr_r[9:8] <= byteIn[1:0];
            end
         end else if (phase_r == eeprom_prot_pkg::PH_DATA &&
                      opcode_r == eeprom_prot_pkg::OP_STAT_WR &&
                      byteCnt_r == eeprom_prot_pkg::BYTE_STAT_DATA) begin
            statusIn_r <= byteIn;
         end
      end
   end

   // a frame counts only if select rises on a byte boundary
   assign frameOk = csRise & (bitCnt_r == 3'h0) &
                    (phase_r == eeprom_prot_pkg::PH_DATA); // RULE14 RULE18
   assign latchSetEv = frameOk & (byteCnt_r == 3'h1) &
                       (opcode_r == eeprom_prot_pkg::OP_LATCH_SET);
   assign latchClrEv = frameOk & (byteCnt_r == 3'h1) &
                       (opcode_r == eeprom_prot_pkg::OP_LATCH_CLR);
   assign statusWrEv = frameOk & (byteCnt_r == 3'h2) &
                       (opcode_r == eeprom_prot_pkg::OP_STAT_WR);
   assign arrayWrEv = frameOk & (byteCnt_r >= eeprom_prot_pkg::BYTE_WR_MIN) &
                      (opcode_r == eeprom_prot_pkg::OP_ARRAY_WR);

   assign hwProt = ~pinsSync.wpN & pinEnable_r; // RULE11 RULE12

   // blocks are aligned wider than a page, so the start address decides
   always_comb begin
      unique case (blockProt_r) // RULE10
         eeprom_prot_pkg::BP_NONE: addrProt = 1'b0;
         eeprom_prot_pkg::BP_QTR: addrProt = (addr_r >= eeprom_prot_pkg::PROT_QTR_BASE);
         eeprom_prot_pkg::BP_HALF: addrProt = (addr_r >= eeprom_prot_pkg::PROT_HALF_BASE);
         eeprom_prot_pkg::BP_ALL: addrProt = 1'b1;
      endcase
   end

   // pin sampled only here; a cycle once begun is not revisited
   assign statusGo = statusWrEv & latch_r & ~hwProt & ~writeBusy; // RULE1 RULE13 RULE19
   assign arrayGo = arrayWrEv & latch_r & ~addrProt & ~writeBusy; // RULE8 RULE13 RULE15
   assign cycleStart = statusGo | arrayGo;

   write_timer #(
      .CYCLES(WR_CYCLE_CLKS)
   ) u_write_timer (
      .clk(mclk),
      .rst_n(rst_n),
      .start(cycleStart),
      .busy(writeBusy), // RULE6
      .done(timerDone)
   );

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         latch_r <= eeprom_prot_pkg::LATCH_RST; // RULE16
      end else if (timerDone) begin
         latch_r <= 1'b0; // RULE3
      end else if (latchClrEv) begin
         latch_r <= 1'b0; // RULE2 RULE3
      end else if (latchSetEv) begin
         latch_r <= 1'b1; // RULE2 RULE7
      end
   end

   // nonvolatile bits change only when their programming cycle ends
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pendStatus_r <= 1'b0;
         pinEnable_r <= eeprom_prot_pkg::NV_PIN_EN_RST;
         blockProt_r <= eeprom_prot_pkg::NV_BP_RST;
      end else if (statusGo) begin
         pendStatus_r <= 1'b1;
      end else if (timerDone && pendStatus_r) begin
         pendStatus_r <= 1'b0;
         pinEnable_r <= statusIn_r[7]; // RULE9 RULE20
         blockProt_r <= statusIn_r[3:2]; // RULE9 RULE20
      end
   end

   always_comb begin
      statusByte.protect_pin_enable = pinEnable_r; // RULE5
      statusByte.dontCare = 3'h0;
      statusByte.block_protect_high = blockProt_r[1];
      statusByte.block_protect_low = blockProt_r[0];
      statusByte.latch_state_bit = latch_r; // RULE7
      statusByte.busy_flag = writeBusy; // RULE6
   end

   // status repeats for as long as the master keeps clocking
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         so_r <= 1'b0;
         soOeN_r <= 1'b1; // RULE16
      end else if (!selected) begin
         soOeN_r <= 1'b1;
      end else if (sckFall && phase_r == eeprom_prot_pkg::PH_STAT) begin
         soOeN_r <= 1'b0; // RULE4
         so_r <= statusByte[3'h7 - bitCnt_r];
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         arrayWrGo_r <= 1'b0;
         arrayWrAddr_r <= 10'h000;
         hwProtected_r <= 1'b0;
      end else begin
         arrayWrGo_r <= arrayGo;
         hwProtected_r <= hwProt;
         if (arrayGo) begin
            arrayWrAddr_r <= addr_r;
         end
      end
   end

   assign so = so_r;
   assign soOeN = soOeN_r;
   assign arrayWrGo = arrayWrGo_r;
   assign arrayWrAddr = arrayWrAddr_r;
   assign hwProtected = hwProtected_r;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   property p_startNeedsLatch;
      $rose(writeBusy) |-> $past(latch_r);
   endproperty
   a_startNeedsLatch: assert property (p_startNeedsLatch) // RULE1
      else $error("write cycle started with latch clear");
   property p_latchSet;
      latchSetEv |=> latch_r ##1 latch_r;
   endproperty
   a_latchSet: assert property (p_latchSet) // RULE2
      else $error("latch-set frame did not set latch");
   property p_doneClears;
      timerDone |=> !latch_r && !writeBusy;
   endproperty
   a_doneClears: assert property (p_doneClears) // RULE3
      else $error("latch or busy survived end of cycle");
   property p_statusDrive;
      sckFall && selected && phase_r == eeprom_prot_pkg::PH_STAT |=>
         !soOeN && so == $past(statusByte[3'h7 - bitCnt_r]);
   endproperty
   a_statusDrive: assert property (p_statusDrive) // RULE4
      else $error("status bit not driven on falling clock");
   property p_busyHolds;
      $rose(writeBusy) |-> writeBusy[*8];
   endproperty
   a_busyHolds: assert property (p_busyHolds) // RULE6
      else $error("busy dropped too early");
   property p_rangeBlocked;
      arrayGo |-> !(blockProt_r == 2'h3 || (blockProt_r == 2'h2 && addr_r[9]) ||
                    (blockProt_r == 2'h1 && addr_r[9:8] == 2'h3));
   endproperty
   a_rangeBlocked: assert property (p_rangeBlocked) // RULE10
      else $error("write started in protected block");
   property p_hwBlocks;
      statusGo |-> pinsSync.wpN || !pinEnable_r;
   endproperty
   a_hwBlocks: assert property (p_hwBlocks) // RULE12
      else $error("status write under hardware protection");
   property p_nvOnlyByWrite;
      $changed(blockProt_r) |-> $past(timerDone) && $past(pendStatus_r);
   endproperty
   a_nvOnlyByWrite: assert property (p_nvOnlyByWrite) // RULE9
      else $error("block-protect changed without status write");
   property p_busyIgnores;
      writeBusy |-> !cycleStart && !latchSetEv && !latchClrEv;
   endproperty
   a_busyIgnores: assert property (p_busyIgnores) // RULE15
      else $error("frame acted on while busy");
   property p_latchFromFrame;
      $rose(latch_r) |-> $past(csRise);
   endproperty
   a_latchFromFrame: assert property (p_latchFromFrame) // RULE18
      else $error("latch set without select rising");
endmodule
`default_nettype wire

// ==== hdl/write_timer.sv ====
`timescale 1ns/10ps
`default_nettype none
module write_timer #(
   parameter int unsigned CYCLES = 16
) (
   input wire logic clk, // system clock
   input wire logic rst_n, // async reset, active low
   input wire logic start, // pulse: begin self-timed cycle
   output logic busy, // cycle running
   output logic done // pulse: cycle finished
);
   localparam int CNT_W = $clog2(CYCLES + 1);
   logic [CNT_W-1:0] cnt_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start && !busy) begin
            busy <= 1'b1;
            cnt_r <= CNT_W'(CYCLES - 1);
         end else if (busy) begin
            if (cnt_r == '0) begin
               busy <= 1'b0;
               done <= 1'b1;
            end else begin
               cnt_r <= cnt_r - 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== testbench/spi_master_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module spi_master_model (
   input wire logic mclk, // system clock, used to pace the serial clock
   input wire logic so, // serial data from the device
   output logic sck, // serial clock, still and low outside frames
   output logic csN, // chip select, active low
   output logic si // serial data to the device
);
   initial begin
      sck = 1'b0;
      csN = 1'b1;
      si = 1'b0;
   end

   // n bits of d go out msb first; rd keeps the last eight bits seen on so.
   // sck is 4 mclk low and 4 high; so is taken mid-high, well clear of its update
   task automatic frame(input logic [31:0] d, input int n, output logic [7:0] rd);
      rd = 8'h00;
      @(negedge mclk);
      csN <= 1'b0;
      repeat (2) @(negedge mclk);
      for (int i = n - 1; i >= 0; i--) begin
         si <= d[i];
         repeat (4) @(negedge mclk);
         sck <= 1'b1;
         repeat (2) @(negedge mclk);
         rd = {rd[6:0], so};
         repeat (2) @(negedge mclk);
         sck <= 1'b0;
      end
      repeat (4) @(negedge mclk);
      // select rises 4 mclk after the last of the n bits, mid-byte when n is not a multiple of eight
      csN <= 1'b1;
      // released data line must not keep looking valid
      si <= ~si;
      repeat (8) @(negedge mclk);
   endtask
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb;
   localparam int unsigned WR_CLKS = 800;
   localparam logic [9:0] ADDRS [6] = '{10'h000, 10'h1ff, 10'h200, 10'h2ff, 10'h300, 10'h3ff};
   logic mclk;
   logic rst_n;
   logic wpN;
   logic sck;
   logic csN;
   logic si;
   logic so;
   // a released output shows the inverse, so a late enable is caught
   logic soLine;
   logic soOeN;
   logic arrayWrGo;
   logic [9:0] arrayWrAddr;
   logic writeBusy;
   logic hwProtected;
   logic [7:0] rd;
   logic [9:0] goAddr = 10'h000;
   int n_fail = 0;
   int samples_checked = 0;
   int busyLen = 0;
   int lastBusyLen = 0;
   int goCount = 0;

   spi_eeprom_write_protect_status #(.WR_CYCLE_CLKS(WR_CLKS)) DUT (
      .mclk(mclk), .rst_n(rst_n), .sck(sck), .csN(csN), .si(si), .wpN(wpN),
      .so(so), .soOeN(soOeN), .arrayWrGo(arrayWrGo), .arrayWrAddr(arrayWrAddr),
      .writeBusy(writeBusy), .hwProtected(hwProtected));

   assign soLine = soOeN ? ~so : so;

   spi_master_model master (.mclk(mclk), .so(soLine), .sck(sck), .csN(csN), .si(si));

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // pulses and busy length are caught here so no scenario can miss them
   always @(posedge mclk) begin
      if (arrayWrGo === 1'b1) begin
         goCount <= goCount + 1;
         goAddr <= arrayWrAddr;
      end
      if (writeBusy === 1'b1) begin
         busyLen <= busyLen + 1;
      end else if (busyLen != 0) begin
         lastBusyLen <= busyLen;
         busyLen <= 0;
      end
   end

   task automatic check(input logic [9:0] got, input logic [9:0] exp, input string msg);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask

   task automatic conclude();
      $display("checks %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic latchSet();
      master.frame({24'h0, eeprom_prot_pkg::OP_LATCH_SET}, 8, rd);
   endtask

   task automatic latchClr();
      master.frame({24'h0, eeprom_prot_pkg::OP_LATCH_CLR}, 8, rd);
   endtask

   task automatic statWr(input logic [7:0] d);
      master.frame({16'h0, eeprom_prot_pkg::OP_STAT_WR, d}, 16, rd);
   endtask

   task automatic arrWr(input logic [9:0] a);
      master.frame({eeprom_prot_pkg::OP_ARRAY_WR, 6'h00, a, 8'h3c}, 32, rd);
   endtask

   task automatic statusIs(input logic [7:0] exp, input string msg);
      master.frame({16'h0, eeprom_prot_pkg::OP_STAT_RD, 8'h00}, 16, rd);
      check(rd, exp, msg);
   endtask

   task automatic waitIdle();
      int k;
      k = 0;
      while (writeBusy !== 1'b0 && k < WR_CLKS + 50) begin
         @(negedge mclk);
         k++;
      end
      if (writeBusy !== 1'b0) begin
         n_fail++;
         $display("Error at %0t: write cycle never ended", $time);
         conclude();
      end else begin
         repeat (2) @(negedge mclk);
      end
   endtask

   task automatic t_power_on();
      check(soOeN, 1'b1, "output off after reset");
      check(writeBusy, 1'b0, "busy after reset");
      statusIs(8'h00, "status after reset");
      check(soOeN, 1'b1, "output off after read");
      $display("done power_on");
   endtask

   task automatic t_latch();
      latchSet();
      statusIs(8'h02, "latch set");
      latchClr();
      statusIs(8'h00, "latch cleared");
      master.frame({16'h0, eeprom_prot_pkg::OP_LATCH_SET, 8'h06}, 16, rd);
      statusIs(8'h00, "set without closing select");
      $display("done latch");
   endtask

   task automatic t_refused();
      int g;
      g = goCount;
      arrWr(10'h010);
      statWr(8'h8c);
      check(10'(goCount - g), 10'h000, "array write without latch");
      check(writeBusy, 1'b0, "cycle without latch");
      statusIs(8'h00, "status kept without latch");
      latchSet();
      master.frame({17'h0, eeprom_prot_pkg::OP_STAT_WR, 7'h46}, 15, rd);
      check(writeBusy, 1'b0, "cut status write frame");
      statusIs(8'h02, "latch kept after cut frame");
      latchClr();
      $display("done refused");
   endtask

   task automatic t_status_write();
      int g;
      latchSet();
      statWr(8'hfc);
      check(writeBusy, 1'b1, "status write cycle");
      wpN = 1'b0;
      statusIs(8'h03, "status during cycle");
      g = goCount;
      arrWr(10'h000);
      latchClr();
      waitIdle();
      check(10'(goCount - g), 10'h000, "array write while busy");
      check(10'(lastBusyLen), 10'(WR_CLKS), "cycle length");
      statusIs(8'h8c, "status after cycle");
      check(hwProtected, 1'b1, "pin low and enabled");
      $display("done status_write");
   endtask

   task automatic t_hw_protect();
      latchSet();
      statWr(8'h00);
      check(writeBusy, 1'b0, "status write under protection");
      statusIs(8'h8e, "bits and latch kept");
      latchClr();
      statusIs(8'h8c, "latch follows clear");
      wpN = 1'b1;
      repeat (6) @(negedge mclk);
      check(hwProtected, 1'b0, "pin high");
      $display("done hw_protect");
   endtask

   task automatic t_ranges();
      logic [1:0] bp;
      logic [9:0] a;
      logic ok;
      int g;
      for (int c = 0; c < 4; c++) begin
         bp = 2'(c);
         latchSet();
         statWr({4'h7, bp, 2'b00});
         waitIdle();
         statusIs({4'h0, bp, 2'b00}, "protect code");
         for (int i = 0; i < 6; i++) begin
            a = ADDRS[i];
            ok = bp == 2'h0 || (bp == 2'h1 && a < 10'h300) || (bp == 2'h2 && a < 10'h200);
            g = goCount;
            latchSet();
            arrWr(a);
            check(10'(goCount - g), {9'h0, ok}, "array write accepted");
            if (ok) begin
               check(goAddr, a, "array write address");
            end
            waitIdle();
            statusIs({4'h0, bp, ~ok, 1'b0}, "latch after array write");
            if (!ok) begin
               latchClr();
            end
         end
      end
      $display("done ranges");
   endtask

   initial begin
      rst_n = 1'b0;
      wpN = 1'b1;
      repeat (12) @(negedge mclk);
      rst_n = 1'b1;
      repeat (4) @(negedge mclk);
      t_power_on();
      t_latch();
      t_refused();
      t_status_write();
      t_hw_protect();
      t_ranges();
      conclude();
   end
endmodule
`default_nettype wire
